// File: logic/ubm_top.sv
// Serial transceiver with fractional baud divider, SPI clock idle level and Manchester coding
`timescale 1ns/1ps
module ubm_top
  import ubm_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic txd,
  input wire logic rxd,
  input wire logic sck_i,
  output logic sck_o,
  output logic sck_oe_n
);
  if (ADDR_W < 8) begin : g_chk
    $error("ADDR_W must be at least 8");
  end

  // Register file
  ubm_mode_type mode_reg;
  ubm_baud_type baud_reg;
  ubm_man_type man_reg;
  logic [10:0] ratio_reg;
  logic wprot_reg;
  logic [7:0] thr_reg;
  logic thr_full_reg;
  logic [7:0] rhr_reg;
  logic rx_ready_reg;
  logic pre_seen_reg;

  // AXI4-Lite slave: address and data are held until both are present
  logic [7:0] awaddr_reg;
  logic aw_full_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic w_full_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [1:0] rresp_reg;
  logic [31:0] rdata_reg;

  assign s_axi_awready = !aw_full_reg && !bvalid_reg;
  assign s_axi_wready = !w_full_reg && !bvalid_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = rdata_reg;

  wire do_wr = aw_full_reg && w_full_reg && !bvalid_reg;
  wire do_rd = s_axi_arvalid && !rvalid_reg;
  wire [7:0] raddr = s_axi_araddr[7:0];
  wire wr_mode = do_wr && awaddr_reg == OFF_MODE;
  wire wr_baud = do_wr && awaddr_reg == OFF_BAUD;
  wire wr_man = do_wr && awaddr_reg == OFF_MAN;
  wire wr_ratio = do_wr && awaddr_reg == OFF_RATIO;
  wire wr_wprot = do_wr && awaddr_reg == OFF_WPROT;
  wire wr_thr = do_wr && awaddr_reg == OFF_THR;
  wire wr_known = wr_mode || wr_baud || wr_man || wr_ratio || wr_wprot || wr_thr;
  wire rd_rhr = do_rd && raddr == OFF_RHR;

  logic [31:0] stat_word;
  logic [31:0] rd_word;
  logic rd_known;
  wire tx_idle;
  always_comb begin
    stat_word = 32'h0000_0000;
    stat_word[ST_RECEIVE_READY_FLAG] = rx_ready_reg;
    stat_word[ST_TRANSMIT_READY_FLAG] = !thr_full_reg;
    stat_word[ST_PRE] = pre_seen_reg;
    stat_word[ST_TXEMPTY] = !thr_full_reg && tx_idle;
    rd_known = 1'b1;
    case (raddr)
      OFF_MODE: rd_word = mode_reg;
      OFF_STAT: rd_word = stat_word;
      OFF_RHR: rd_word = {24'h000000, rhr_reg};
      OFF_BAUD: rd_word = baud_reg;
      OFF_RATIO: rd_word = {21'h000000, ratio_reg};
      OFF_MAN: rd_word = man_reg;
      OFF_WPROT: rd_word = {31'h0000_0000, wprot_reg};
      OFF_THR: rd_word = 32'h0000_0000;
      default: begin
        rd_word = 32'h0000_0000;
        rd_known = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_reg <= 1'b1;
        awaddr_reg <= {s_axi_awaddr[7:2], 2'b00};
      end else if (do_wr) begin
        aw_full_reg <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end else if (do_wr) begin
        w_full_reg <= 1'b0;
      end
      if (do_wr) begin
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_known ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rresp_reg <= RESP_OKAY;
      rdata_reg <= 32'h0000_0000;
    end else if (do_rd) begin
      rvalid_reg <= 1'b1;
      rresp_reg <= rd_known ? RESP_OKAY : RESP_SLVERR;
      rdata_reg <= rd_word;
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_reg <= REG_RST;
      baud_reg <= REG_RST;
      man_reg <= REG_RST;
      ratio_reg <= RATIO_RST;
      wprot_reg <= 1'b0;
    end else begin
      if (wr_mode) mode_reg <= ubm_merge(mode_reg, wdata_reg, wstrb_reg, MODE_MASK);
      if (wr_baud && !wprot_reg) baud_reg <= ubm_merge(baud_reg, wdata_reg, wstrb_reg, BAUD_MASK);
      if (wr_man && !wprot_reg) man_reg <= ubm_merge(man_reg, wdata_reg, wstrb_reg, MAN_MASK);
      if (wr_ratio && wstrb_reg[0]) ratio_reg[7:0] <= wdata_reg[7:0];
      if (wr_ratio && wstrb_reg[1]) ratio_reg[10:8] <= wdata_reg[10:8];
      if (wr_wprot && wstrb_reg[0]) wprot_reg <= wdata_reg[0];
    end
  end

  // Selected clock and bit-period factor
  wire spi = mode_reg.mode == MODE_SPI_M || mode_reg.mode == MODE_SPI_S;
  wire iso = mode_reg.mode == MODE_ISO;
  wire man = mode_reg.man_en;
  logic [2:0] pre_reg;
  logic sck_d_reg;
  logic src_en;
  logic tick;
  logic [15:0] factor;
  always_comb begin
    case (mode_reg.clock_source_select)
      CKS_DIV: src_en = pre_reg == PRESCALE_LAST;
      CKS_EXT: src_en = sck_i && !sck_d_reg;
      default: src_en = 1'b1;
    endcase
    if (iso) begin
      factor = ratio_reg == 11'h000 ? FAC_SYNC : {5'h00, ratio_reg};
    end else if (mode_reg.sync || spi) begin
      factor = FAC_SYNC;
    end else begin
      factor = mode_reg.over ? FAC_OVER : FAC_ASYNC;
    end
  end
  wire [15:0] half = factor == FAC_SYNC ? FAC_SYNC : factor >> 1;
  wire [15:0] quarter = factor < 16'h0004 ? FAC_SYNC : factor >> 2;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre_reg <= 3'h0;
      sck_d_reg <= 1'b0;
    end else begin
      pre_reg <= pre_reg + 3'h1;
      sck_d_reg <= sck_i;
    end
  end

  ubm_baud_gen u_baud (
    .aclk(aclk),
    .aresetn(aresetn),
    .src_en(src_en),
    .divider(baud_reg.clock_divider),
    .frac(baud_reg.fractional_part),
    .tick(tick)
  );

  // Transmitter
  ubm_tx_st_type tx_st_reg;
  ubm_tx_st_type tx_st_next;
  logic [15:0] tx_ph_reg;
  logic [3:0] tx_idx_reg;
  logic [7:0] tx_sh_reg;
  logic tx_h2_reg;
  logic tx_cur;
  assign tx_idle = tx_st_reg == TX_IDLE;
  wire tx_go = tx_idle && thr_full_reg && (!mode_reg.wait_for_read_option || !rx_ready_reg);
  wire tx_end = tick && tx_ph_reg == factor - 16'h0001;
  wire tx_mid = tick && tx_ph_reg == half - 16'h0001;
  wire tx_pre_on = man && man_reg.transmit_preamble_length != 4'h0;
  wire tx_pre_last = tx_idx_reg == man_reg.transmit_preamble_length - 4'h1;

  always_comb begin
    tx_st_next = tx_st_reg;
    case (tx_st_reg)
      TX_IDLE: tx_cur = 1'b1;
      TX_PRE: tx_cur = ubm_pre_bit(man_reg.transmit_preamble_pattern, tx_idx_reg);
      TX_START: tx_cur = 1'b0;
      TX_DATA: tx_cur = tx_sh_reg[0];
      default: tx_cur = 1'b1;
    endcase
    case (tx_st_reg)
      TX_IDLE: if (tx_go) tx_st_next = tx_pre_on ? TX_PRE : TX_START;
      TX_PRE: if (tx_end && tx_pre_last) tx_st_next = TX_START;
      TX_START: if (tx_end) tx_st_next = TX_DATA;
      TX_DATA: if (tx_end && tx_idx_reg == DATA_LAST) tx_st_next = TX_STOP;
      TX_STOP: if (tx_end) tx_st_next = TX_IDLE;
      default: tx_st_next = TX_IDLE;
    endcase
  end

  // First half carries the bit, second half its complement; polarity inverts both
  wire tx_level = man ? tx_cur ^ man_reg.transmit_coding_polarity ^ tx_h2_reg : tx_cur;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_st_reg <= TX_IDLE;
      tx_ph_reg <= 16'h0000;
      tx_idx_reg <= 4'h0;
      tx_sh_reg <= 8'h00;
      tx_h2_reg <= 1'b0;
      txd <= 1'b1;
    end else begin
      tx_st_reg <= tx_st_next;
      txd <= tx_idle ? 1'b1 : tx_level;
      if (tx_go) begin
        tx_sh_reg <= thr_reg;
      end else if (tx_end && tx_st_reg == TX_DATA) begin
        tx_sh_reg <= {1'b0, tx_sh_reg[7:1]};
      end
      if (tx_idle || tx_end) begin
        tx_ph_reg <= 16'h0000;
      end else if (tick) begin
        tx_ph_reg <= tx_ph_reg + 16'h0001;
      end
      if (tx_idle || tx_end) begin
        tx_h2_reg <= 1'b0;
      end else if (tx_mid) begin
        tx_h2_reg <= 1'b1;
      end
      if (tx_idle || (tx_end && tx_st_next != tx_st_reg)) begin
        tx_idx_reg <= 4'h0;
      end else if (tx_end) begin
        tx_idx_reg <= tx_idx_reg + 4'h1;
      end
    end
  end

  // Serial clock: idle level from polarity, toggles at mid-bit while shifting unless the bit-period factor is one
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sck_o <= 1'b0;
      sck_oe_n <= 1'b1;
    end else begin
      sck_o <= mode_reg.clock_idle_polarity ^ (!tx_idle && tx_h2_reg);
      sck_oe_n <= !(mode_reg.clock_output_select && mode_reg.clock_source_select != CKS_EXT);
    end
  end

  // Receiver
  ubm_rx_st_type rx_st_reg;
  ubm_rx_st_type rx_st_next;
  logic [15:0] rx_ph_reg;
  logic [3:0] rx_idx_reg;
  logic [7:0] rx_sh_reg;
  logic rxd_d_reg;
  logic rx_bit_reg;
  wire rx_fall = rxd_d_reg && !rxd;
  wire rx_samp = tick && rx_ph_reg == (man ? quarter : half) - 16'h0001;
  wire rx_end = tick && rx_ph_reg == factor - 16'h0001;
  wire rx_pre_on = man && man_reg.receive_preamble_length != 4'h0;
  wire rx_pre_last = rx_idx_reg == man_reg.receive_preamble_length - 4'h1;
  wire rx_pre_exp = ubm_pre_bit(man_reg.receive_preamble_pattern, rx_idx_reg);
  wire rx_s = rxd ^ (man && man_reg.receive_coding_polarity);
  wire rx_done = rx_st_reg == RX_STOP && rx_end && rx_bit_reg;

  always_comb begin
    rx_st_next = rx_st_reg;
    case (rx_st_reg)
      RX_IDLE: if (rx_fall) rx_st_next = rx_pre_on ? RX_PRE : RX_START;
      RX_PRE: begin
        if (rx_samp && rx_s != rx_pre_exp) rx_st_next = RX_IDLE;
        else if (rx_end && rx_pre_last) rx_st_next = RX_START;
      end
      RX_START: begin
        if (rx_samp && rx_s) rx_st_next = RX_IDLE;
        else if (rx_end) rx_st_next = RX_DATA;
      end
      RX_DATA: if (rx_end && rx_idx_reg == DATA_LAST) rx_st_next = RX_STOP;
      RX_STOP: if (rx_end) rx_st_next = RX_IDLE;
      default: rx_st_next = RX_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_st_reg <= RX_IDLE;
      rx_ph_reg <= 16'h0000;
      rx_idx_reg <= 4'h0;
      rx_sh_reg <= 8'h00;
      rxd_d_reg <= 1'b1;
      rx_bit_reg <= 1'b0;
    end else begin
      rx_st_reg <= rx_st_next;
      rxd_d_reg <= rxd;
      if (rx_samp) rx_bit_reg <= rx_s;
      if (rx_samp && rx_st_reg == RX_DATA) rx_sh_reg <= {rx_s, rx_sh_reg[7:1]};
      if (rx_st_reg == RX_IDLE || rx_end) begin
        rx_ph_reg <= 16'h0000;
      end else if (tick) begin
        rx_ph_reg <= rx_ph_reg + 16'h0001;
      end
      if (rx_st_reg == RX_IDLE || (rx_end && rx_st_next != rx_st_reg)) begin
        rx_idx_reg <= 4'h0;
      end else if (rx_end) begin
        rx_idx_reg <= rx_idx_reg + 4'h1;
      end
    end
  end

  // Holding registers and flags; a hardware set beats a same-cycle software clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      thr_reg <= 8'h00;
      thr_full_reg <= 1'b0;
      rhr_reg <= 8'h00;
      rx_ready_reg <= 1'b0;
      pre_seen_reg <= 1'b0;
    end else begin
      if (wr_thr && !thr_full_reg && wstrb_reg[0]) begin
        thr_reg <= wdata_reg[7:0];
        thr_full_reg <= 1'b1;
      end else if (tx_go) begin
        thr_full_reg <= 1'b0;
      end
      if (rx_done) begin
        rhr_reg <= rx_sh_reg;
        rx_ready_reg <= 1'b1;
      end else if (rd_rhr) begin
        rx_ready_reg <= 1'b0;
      end
      if (rx_st_reg == RX_PRE && rx_st_next == RX_START) begin
        pre_seen_reg <= 1'b1;
      end else if (rd_rhr) begin
        pre_seen_reg <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence spi_idle_s;
    spi && tx_idle ##1 tx_idle;
  endsequence
  spi_idle_level_a: assert property (spi_idle_s |-> sck_o == $past(mode_reg.clock_idle_polarity))
    else $error("serial clock not at idle polarity");
  clk_undriven_a: assert property ($past(!mode_reg.clock_output_select) |-> sck_oe_n)
    else $error("serial clock driven with output off");
  tx_prompt_a: assert property (tx_idle && thr_full_reg && !mode_reg.wait_for_read_option
                                |=> !tx_idle && !thr_full_reg)
    else $error("character not started at once");
  tx_waits_a: assert property (tx_idle && rx_ready_reg && mode_reg.wait_for_read_option && !rd_rhr
                               |=> tx_idle)
    else $error("transmission started before data read");
  wp_baud_a: assert property (wr_baud && wprot_reg |=> $stable(baud_reg))
    else $error("protected baud register changed");
  wp_man_a: assert property (wr_man && wprot_reg |=> $stable(man_reg))
    else $error("protected Manchester register changed");
  async_factor_a: assert property (!iso && !spi && !mode_reg.sync
                                   |-> factor == (mode_reg.over ? 16'h0008 : 16'h0010))
    else $error("asynchronous oversampling factor wrong");
  sync_factor_a: assert property (!iso && (spi || mode_reg.sync) |-> factor == 16'h0001)
    else $error("synchronous factor not one");
  iso_factor_a: assert property (iso && ratio_reg != 11'h000 |-> factor == {5'h00, ratio_reg})
    else $error("smart-card factor wrong");
  tx_nopre_a: assert property (tx_st_reg == TX_PRE |-> tx_pre_on)
    else $error("preamble sent while disabled");
  rx_nopre_a: assert property (rx_st_reg == RX_PRE |-> rx_pre_on)
    else $error("preamble searched while disabled");
  first_half_a: assert property (man && !tx_idle && !tx_h2_reg && tx_st_reg != TX_IDLE ##1 $stable(man)
                                 |-> txd == ($past(tx_cur) ^ $past(man_reg.transmit_coding_polarity)))
    else $error("Manchester first half wrong");
  mid_flip_a: assert property (man && tx_mid && !tx_end && tx_st_reg != TX_IDLE ##1 $stable(man) ##1 1'b1
                               |-> txd != $past(txd))
    else $error("Manchester mid-bit transition missing");
  rx_set_wins_a: assert property (rx_done |=> rx_ready_reg ##0 rhr_reg == $past(rx_sh_reg))
    else $error("received character lost");
endmodule

// File: logic/ubm_pkg.sv
// Constants, carriers and helpers for the serial baud and Manchester configuration block
// How it works
// - In SPI modes 0xE/0xF the clock pin idles at the programmed idle polarity.
// - Clock pin undriven unless clock output is set and source is not external.
// - Without wait-for-read, a written character starts as soon as it is taken.
// - With wait-for-read, transmission waits until received data has been read.
// - Baud and Manchester register writes are dropped while write protection is on.
// - Divider zero stops the baud clock; 1 to 65535 divide.
// - Asynchronous bit period is divider times 16, or times 8 when oversampling.
// - Synchronous and SPI bit period is the divider alone.
// - Smart-card bit period is divider times the smart-card rate ratio, or the divider alone when the ratio is zero.
// - Fraction zero disables; 1 to 7 add that many eighths to the divider.
// - Transmit preamble length zero disables; otherwise that many bit periods sent.
// - Transmit preamble code picks ones, zeros, zero-one or one-zero.
// - Coding polarity 0: zero is low-to-high, one is high-to-low.
// - Coding polarity 1: zero is high-to-low, one is low-to-high.
// - Receive preamble length zero disables detection; otherwise that many bits expected.
// - Receive preamble code picks ones, zeros, zero-one or one-zero.
package ubm_pkg;
  localparam logic [7:0] OFF_MODE = 8'h04;
  localparam logic [7:0] OFF_STAT = 8'h14;
  localparam logic [7:0] OFF_RHR = 8'h18;
  localparam logic [7:0] OFF_THR = 8'h1C;
  localparam logic [7:0] OFF_BAUD = 8'h20;
  localparam logic [7:0] OFF_RATIO = 8'h40;
  localparam logic [7:0] OFF_MAN = 8'h50;
  localparam logic [7:0] OFF_WPROT = 8'hE4;
  localparam logic [31:0] MODE_MASK = 32'h201D_013F;
  localparam logic [31:0] BAUD_MASK = 32'h0007_FFFF;
  localparam logic [31:0] MAN_MASK = 32'h530F_130F;
  localparam logic [31:0] REG_RST = 32'h0000_0000;
  localparam logic [10:0] RATIO_RST = 11'h001;
  localparam logic [3:0] MODE_ISO = 4'h4;
  localparam logic [3:0] MODE_SPI_M = 4'hE;
  localparam logic [3:0] MODE_SPI_S = 4'hF;
  localparam logic [1:0] CKS_DIV = 2'h1;
  localparam logic [1:0] CKS_EXT = 2'h3;
  localparam logic [2:0] PRESCALE_LAST = 3'h7;
  localparam logic [15:0] FAC_ASYNC = 16'h0010;
  localparam logic [15:0] FAC_OVER = 16'h0008;
  localparam logic [15:0] FAC_SYNC = 16'h0001;
  localparam logic [3:0] DATA_LAST = 4'h7;
  localparam int ST_RECEIVE_READY_FLAG = 0;
  localparam int ST_TRANSMIT_READY_FLAG = 1;
  localparam int ST_PRE = 2;
  localparam int ST_TXEMPTY = 9;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [1:0] rsv31;
    logic man_en;
    logic [7:0] rsv28;
    logic wait_for_read_option;
    logic over;
    logic clock_output_select;
    logic rsv17;
    logic clock_idle_polarity;
    logic [6:0] rsv15;
    logic sync;
    logic [1:0] rsv7;
    logic [1:0] clock_source_select;
    logic [3:0] mode;
  } ubm_mode_type;

  typedef struct packed {
    logic [12:0] rsv31;
    logic [2:0] fractional_part;
    logic [15:0] clock_divider;
  } ubm_baud_type;

  typedef struct packed {
    logic rsv31;
    logic drift;
    logic one;
    logic receive_coding_polarity;
    logic [1:0] rsv27;
    logic [1:0] receive_preamble_pattern;
    logic [3:0] rsv23;
    logic [3:0] receive_preamble_length;
    logic [2:0] rsv15;
    logic transmit_coding_polarity;
    logic [1:0] rsv11;
    logic [1:0] transmit_preamble_pattern;
    logic [3:0] rsv7;
    logic [3:0] transmit_preamble_length;
  } ubm_man_type;

  typedef enum logic [2:0] {
    TX_IDLE = 3'b000, TX_PRE = 3'b001, TX_START = 3'b010, TX_DATA = 3'b011, TX_STOP = 3'b100
  } ubm_tx_st_type;

  typedef enum logic [2:0] {
    RX_IDLE = 3'b000, RX_PRE = 3'b001, RX_START = 3'b010, RX_DATA = 3'b011, RX_STOP = 3'b100
  } ubm_rx_st_type;

  // Preamble bit at position idx for a pattern code
  function automatic logic ubm_pre_bit(input logic [1:0] pp, input logic [3:0] idx);
    case (pp)
      2'h0: ubm_pre_bit = 1'b1;
      2'h1: ubm_pre_bit = 1'b0;
      2'h2: ubm_pre_bit = idx[0];
      default: ubm_pre_bit = ~idx[0];
    endcase
  endfunction

  // Byte-lane merge of a bus write into a register image
  function automatic logic [31:0] ubm_merge(input logic [31:0] old, input logic [31:0] wd,
                                            input logic [3:0] strb, input logic [31:0] mask);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    ubm_merge = r & mask;
  endfunction
endpackage

// File: logic/ubm_baud_gen.sv
// Fractional baud-rate tick generator
`timescale 1ns/1ps
module ubm_baud_gen
  import ubm_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic src_en,
  input wire logic [15:0] divider,
  input wire logic [2:0] frac,
  output logic tick
);
  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  logic [2:0] acc_reg;
  logic [3:0] acc_sum;
  wire run = divider != 16'h0000;

  // Carry out of the eighths accumulator stretches the next period by one source clock
  assign acc_sum = {1'b0, acc_reg} + {1'b0, frac};
  assign tick = run && src_en && cnt_reg == 16'h0000;
  assign cnt_next = acc_sum[3] ? divider : divider - 16'h0001;

  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      cnt_reg <= 16'h0000;
      acc_reg <= 3'h0;
    end else if (tick) begin
      cnt_reg <= cnt_next;
      acc_reg <= acc_sum[2:0];
    end else if (src_en) begin
      cnt_reg <= cnt_reg - 16'h0001;
    end
  end

  // Helper: source events since the previous tick, valid only while the setting is steady
  logic [16:0] gap_reg;
  logic steady_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn || tick) begin
      gap_reg <= 17'h00000;
      steady_reg <= aresetn;
    end else begin
      gap_reg <= src_en ? gap_reg + 17'h00001 : gap_reg;
      steady_reg <= steady_reg && $stable(divider) && $stable(frac);
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  stopped_clock_a: assert property (divider == 16'h0000 |-> !tick)
    else $error("baud tick while divider is zero");
  whole_period_a: assert property (tick && steady_reg && frac == 3'h0 && $past(tick) == 1'b0
                                   |-> gap_reg + 17'h00001 == {1'b0, divider})
    else $error("integer baud period wrong");
  frac_period_a: assert property (tick && steady_reg && $past(tick) == 1'b0
                                  |-> gap_reg + 17'h00001 == {1'b0, divider}
                                   || gap_reg == {1'b0, divider})
    else $error("fractional baud period out of range");
endmodule

// File: verif/ubm_peer.sv
// Remote serial peer that drives the receive line
`timescale 1ns/1ps
module ubm_peer(
  input wire logic aclk,
  output logic rxd
);
  initial rxd = 1'b1;
  // One plain frame, LSB first, at a bit period of bit_cyc clocks
  task automatic send(input logic [7:0] b, input int bit_cyc);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxd <= f[i];
      repeat (bit_cyc) @(posedge aclk);
    end
  endtask
  // Manchester frame with one zero preamble bit; each bit is its level then its complement
  task automatic send_man(input logic [7:0] b, input int half_cyc);
    logic [10:0] f;
    f = {1'b1, b, 1'b0, 1'b0};
    for (int i = 0; i < 11; i++) begin
      rxd <= f[i];
      repeat (half_cyc) @(posedge aclk);
      rxd <= ~f[i];
      repeat (half_cyc) @(posedge aclk);
    end
    rxd <= 1'b1;
  endtask
endmodule

// File: verif/ubm_top_tb.sv
// Self-checking bench for the serial baud and Manchester block
`timescale 1ns/1ps
module ubm_top_tb;
  import ubm_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, d;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [33:0] q[$], qe;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, txd, rxd, sck_o, sck_oe_n;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] tm[7] = '{32'h0, 32'h8_0000, 32'h100, 32'h4, 32'h2000_0000, 32'h2000_0000, 32'h2000_0000};
  logic [31:0] tn[7] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h1000, 32'h1};
  int tw[7] = '{16, 8, 1, 3, 8, 16, 16};
  logic [31:0] sm[3] = '{32'h5_000E, 32'h4_003E, 32'hF};
  logic [31:0] se[3] = '{32'h1, 32'h2, 32'h2};
  int err_total = 0, num_checks = 0;
  ubm_top u_dut(.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .txd, .rxd, .sck_i(1'b0), .sck_o, .sck_oe_n);
  ubm_peer u_peer(.aclk, .rxd);
  initial forever #25 aclk = ~aclk;
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    num_checks++;
    if (s !== e) begin
      $display("mismatch %s expected %h seen %h", n, e, s);
      err_total++;
    end
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Handshake state is sampled at the falling edge, where it is settled
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic ta, tw, tb;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int n = 0; n < 50; n++) begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tb) begin
        chk("bresp", {30'h0, (a == 8'hF0 ? RESP_SLVERR : RESP_OKAY)}, {30'h0, s_axi_bresp});
        s_axi_bready <= 1'b0;
        return;
      end
    end
    err_total++;
    summarize();
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic ta, tr;
    @(posedge aclk);
    q.push_back({(a == 8'hF0 ? RESP_SLVERR : RESP_OKAY), e});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int n = 0; n < 50; n++) begin
      @(negedge aclk);
      ta = s_axi_arvalid && s_axi_arready;
      tr = s_axi_rvalid;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
      if (tr) begin
        s_axi_rready <= 1'b0;
        return;
      end
    end
    err_total++;
    summarize();
  endtask
  always @(negedge aclk) begin
    if (s_axi_rvalid && s_axi_rready) begin
      qe = q.pop_front();
      chk("rdata", qe[31:0], s_axi_rdata);
      chk("rresp", {30'h0, qe[33:32]}, {30'h0, s_axi_rresp});
    end
  end
  // Width of the first low stretch on txd; zero if none within the bound
  task automatic low_w(input int e);
    int w;
    w = 0;
    for (int n = 0; n < 400 && txd; n++) @(negedge aclk);
    while (!txd && w < 400) begin
      @(negedge aclk);
      w++;
    end
    chk("low width", 32'(e), 32'(w));
  endtask
  initial begin
    repeat (60000) @(posedge aclk);
    err_total++;
    summarize();
  end
  initial begin
    void'($urandom(74));
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h20, 32'h0);
    rd(8'h50, 32'h0);
    rd(8'h40, 32'h1);
    wr(8'hF0, 32'hFFFF_FFFF);
    rd(8'hF0, 32'h0);
    wr(8'h20, 32'hFFFF_FFFF);
    rd(8'h20, 32'h0007_FFFF);
    wr(8'hE4, 32'h1);
    wr(8'h20, 32'h2);
    wr(8'h50, 32'h1);
    rd(8'h20, 32'h0007_FFFF);
    rd(8'h50, 32'h0);
    wr(8'hE4, 32'h0);
    // A long count left by the 0xFFFF divider only clears while the divider is zero
    wr(8'h20, 32'h0);
    wr(8'h20, 32'h3);
    repeat (40) @(posedge aclk);
    wr(8'h20, 32'h3_0003);
    repeat (100) @(posedge aclk);
    // Divider 1 ticks every clock, so bit edges sit at fixed offsets from the write
    wr(8'h20, 32'h1);
    wr(8'h40, 32'h3);
    for (int i = 0; i < 3; i++) begin
      wr(8'h04, sm[i]);
      repeat (3) @(negedge aclk);
      chk("sck", se[i], {30'h0, sck_oe_n, sck_o});
    end
    // Width of the first low stretch per mode; data bit 0 is forced high so the stretch ends by the middle of that bit
    for (int i = 0; i < 7; i++) begin
      wr(8'h04, tm[i]);
      wr(8'h50, tn[i]);
      d = 8'($urandom) | 8'h01;
      wr(8'h1C, {24'h0, d});
      low_w(tw[i]);
      repeat (500) @(posedge aclk);
    end
    wr(8'h04, 32'h10_0000);
    u_peer.send(8'hA5, 16);
    repeat (40) @(posedge aclk);
    wr(8'h1C, 32'h5B);
    low_w(0);
    rd(8'h18, 32'hA5);
    low_w(16);
    repeat (200) @(posedge aclk);
    // Manchester frame led by one preamble bit of zeros
    wr(8'h04, 32'h2000_0000);
    wr(8'h50, 32'h0101_0000);
    u_peer.send_man(8'hC3, 8);
    repeat (40) @(posedge aclk);
    rd(8'h14, 32'h207);
    rd(8'h18, 32'hC3);
    summarize();
  end
endmodule
